// File: include/status_io_params.svh
// Constants for the status and switching I/O byte block
`ifndef STATUS_IO_PARAMS_SVH
`define STATUS_IO_PARAMS_SVH
`define CLK_FREQ_HZ 125000000
`define TICK_TIME_MS 1
`define TICK_CYCLES ((`CLK_FREQ_HZ / 1000) * `TICK_TIME_MS)
`define HEARTBEAT_TIME_MS 1000
`define DEBOUNCE_TIME_MS 20
`define SUPERVISION_TIME_MS 50
`define BIT_SERIAL_FAULT 7
`define BIT_BUFFERS_FULL 6
`define BIT_READER_REJECT 5
`define BIT_READER_TIMEOUT 4
`define BIT_MASTER_FAULT 3
`define BIT_HEARTBEAT 2
`define BIT_SWITCH_TWO 1
`define BIT_SWITCH_ONE 0
`define OUTPUT_BYTE_RESET 8'h00
`define FLASH_REGULAR_MS 500
`define FLASH_CYCLIC_MS 250
`endif

// File: include/status_io_pkg.sv
// Types for the status and switching I/O byte block
package status_io_pkg;
  typedef enum logic [2:0] {
    XFER_IDLE = 3'b001,
    XFER_BUSY = 3'b010,
    XFER_ACKED = 3'b100
  } xfer_state_t;
  typedef enum logic [1:0] {
    LAMP_OFF = 2'h0,
    LAMP_ON = 2'h1,
    LAMP_REGULAR = 2'h2,
    LAMP_IRREGULAR = 2'h3
  } lamp_mode_t;
endpackage : status_io_pkg

// File: core/input_debouncer.sv
// Debounce filter for one switching input
`timescale 1ns/1ps
`include "status_io_params.svh"
module input_debouncer #(
  parameter int unsigned STABLE_TICKS = `DEBOUNCE_TIME_MS
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic tick_in,
  input wire logic raw_in,
  output logic level_out
);
  logic [7:0] count;
  logic [7:0] next_count;
  logic level;
  logic next_level;

  // Level follows raw only after it stays different for the full window
  always_comb
  begin
    next_count = count;
    next_level = level;
    if (raw_in == level)
    begin
      next_count = 8'h00;
    end
    else if (tick_in)
    begin
      if (count >= 8'(STABLE_TICKS - 1))
      begin
        next_level = raw_in;
        next_count = 8'h00;
      end
      else
      begin
        next_count = count + 8'h01;
      end
    end
  end

  // Filter state
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      count <= 8'h00;
      level <= 1'b0;
    end
    else
    begin
      count <= next_count;
      level <= next_level;
    end
  end

  assign level_out = level;
endmodule : input_debouncer

// File: core/gateway_status_io_byte.sv
// Status byte builder, switching outputs and system lamp encoder
//
// What this block does
// - Status byte in, output byte out, header one
// - Bit 7 flags serial line receive error
// - Bit 6 flags full buffers; refuse data
// - Bit 5 flags reader negative acknowledge
// - Bit 4 flags reader silent 50 ms
// - Bit 3 flags master fault; refuse, resync
// - Bit 2 toggles every one second
// - Bits 0, 1 report switching inputs
// - Inputs debounced 20 ms before reporting
// - Error bits set when transfer acknowledged
// - Error bits cleared when master counter changes
// - Output bits 0, 1 drive switching outputs
// - Green run lamp shows communication state
// - Yellow ready lamp shows device state
`timescale 1ns/1ps
`include "status_io_params.svh"
module gateway_status_io_byte
  import status_io_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES,
  parameter int unsigned HEARTBEAT_TICKS = `HEARTBEAT_TIME_MS,
  parameter int unsigned DEBOUNCE_TICKS = `DEBOUNCE_TIME_MS,
  parameter int unsigned SUPERVISION_TICKS = `SUPERVISION_TIME_MS
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic switch_input_one_in,
  input wire logic switch_input_two_in,
  input wire logic [7:0] output_control_byte_in,
  input wire logic output_control_write_in,
  input wire logic [7:0] master_outbound_counter_in,
  input wire logic serial_line_fault_in,
  input wire logic outbound_buffers_full_in,
  input wire logic reader_rejected_telegram_in,
  input wire logic reader_telegram_sent_in,
  input wire logic reader_response_in,
  input wire logic master_handling_fault_in,
  input wire logic transfer_done_in,
  input wire logic [1:0] run_mode_in,
  input wire logic [1:0] ready_mode_in,
  output logic [7:0] input_status_byte_out,
  output logic [7:0] echoed_outbound_counter_out,
  output logic transfer_accept_out,
  output logic resync_request_out,
  output logic switch_output_one_out,
  output logic switch_output_two_out,
  output logic run_lamp_out,
  output logic ready_lamp_out
);
  logic [16:0] prescale;
  logic [16:0] next_prescale;
  logic tick;
  logic next_tick;
  logic [9:0] ms_count;
  logic [9:0] next_ms_count;
  logic heartbeat;
  logic next_heartbeat;
  logic [5:0] sup_count;
  logic [5:0] next_sup_count;
  logic sup_active;
  logic next_sup_active;
  logic [4:0] pend;
  logic [4:0] next_pend;
  logic [4:0] err;
  logic [4:0] next_err;
  logic [7:0] echo;
  logic [7:0] next_echo;
  logic [7:0] seen_count;
  logic [7:0] next_seen_count;
  xfer_state_t state;
  xfer_state_t next_state;
  logic [1:0] outs;
  logic [1:0] next_outs;
  logic run_lamp;
  logic next_run_lamp;
  logic ready_lamp;
  logic next_ready_lamp;
  logic accept, next_accept;
  logic sw_one;
  logic sw_two;
  logic timeout_evt;

  // Debounced switching inputs
  input_debouncer #(.STABLE_TICKS(DEBOUNCE_TICKS)) u_deb_one (
    .clk_in(clk_in), .reset_in(reset_in), .tick_in(tick),
    .raw_in(switch_input_one_in), .level_out(sw_one));
  input_debouncer #(.STABLE_TICKS(DEBOUNCE_TICKS)) u_deb_two (
    .clk_in(clk_in), .reset_in(reset_in), .tick_in(tick),
    .raw_in(switch_input_two_in), .level_out(sw_two));

  // Millisecond tick, heartbeat and lamp patterns from one prescaler
  always_comb
  begin
    next_tick = 1'b0;
    next_prescale = prescale + 17'h00001;
    next_ms_count = ms_count;
    next_heartbeat = heartbeat;
    if (prescale >= 17'(TICK_CYCLES - 1))
    begin
      next_prescale = 17'h00000;
      next_tick = 1'b1;
      next_ms_count = ms_count + 10'h001;
      if (ms_count >= 10'(HEARTBEAT_TICKS - 1))
      begin
        next_ms_count = 10'h000;
        next_heartbeat = ~heartbeat;
      end
    end
  end

  // Reader supervision window after each telegram sent
  always_comb
  begin
    next_sup_active = sup_active;
    next_sup_count = sup_count;
    timeout_evt = 1'b0;
    if (reader_telegram_sent_in)
    begin
      next_sup_active = 1'b1;
      next_sup_count = 6'h00;
    end
    else if (reader_response_in)
    begin
      next_sup_active = 1'b0;
    end
    else if (sup_active && tick)
    begin
      if (sup_count >= 6'(SUPERVISION_TICKS - 1))
      begin
        timeout_evt = 1'b1;
        next_sup_active = 1'b0;
      end
      else
      begin
        next_sup_count = sup_count + 6'h01;
      end
    end
  end

  // Transfer handshake; pending errors latch into status on acknowledge
  always_comb
  begin
    next_state = state;
    next_echo = echo;
    next_seen_count = seen_count;
    next_err = err;
    next_outs = outs;
    // Events collect between transfers; an event in the acknowledge cycle goes to err while pend clears
    next_pend = pend | {serial_line_fault_in, outbound_buffers_full_in,
      reader_rejected_telegram_in, timeout_evt, master_handling_fault_in};
    if (output_control_write_in)
    begin
      next_outs = output_control_byte_in[1:0];
    end
    unique case (state)
      XFER_IDLE, XFER_ACKED:
      begin
        if (master_outbound_counter_in != seen_count)
        begin
          next_seen_count = master_outbound_counter_in;
          next_err = 5'h00;
          next_state = XFER_BUSY;
        end
      end
      XFER_BUSY:
      begin
        if (transfer_done_in || outbound_buffers_full_in || master_handling_fault_in)
        begin
          next_echo = seen_count;
          next_err = next_pend;
          next_pend = 5'h00;
          next_state = XFER_ACKED;
        end
      end
    endcase
    next_accept = ~next_err[`BIT_BUFFERS_FULL - 3] & ~next_err[`BIT_MASTER_FAULT - 3];
  end

  // Lamp encoders for run and ready indicators
  always_comb
  begin
    next_run_lamp = 1'b0;
    next_ready_lamp = 1'b0;
    unique case (lamp_mode_t'(run_mode_in))
      LAMP_OFF: next_run_lamp = 1'b0;
      LAMP_ON: next_run_lamp = 1'b1;
      LAMP_REGULAR: next_run_lamp = ms_count[8];
      LAMP_IRREGULAR: next_run_lamp = ms_count[8] & ms_count[6];
    endcase
    unique case (lamp_mode_t'(ready_mode_in))
      LAMP_OFF: next_ready_lamp = 1'b0;
      LAMP_ON: next_ready_lamp = 1'b1;
      LAMP_REGULAR: next_ready_lamp = ms_count[7];
      LAMP_IRREGULAR: next_ready_lamp = ms_count[8] & ms_count[5];
    endcase
  end
  // State registers; reset clears all but state, loaded with XFER_IDLE, and accept, set to 1
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      prescale <= 17'h00000;
      tick <= 1'b0;
      ms_count <= 10'h000;
      heartbeat <= 1'b0;
      sup_count <= 6'h00;
      sup_active <= 1'b0;
      pend <= 5'h00;
      err <= 5'h00;
      echo <= 8'h00;
      seen_count <= 8'h00;
      state <= XFER_IDLE;
      outs <= 2'h0;
      run_lamp <= 1'b0;
      ready_lamp <= 1'b0;
      accept <= 1'b1;
    end
    else
    begin
      prescale <= next_prescale;
      tick <= next_tick;
      ms_count <= next_ms_count;
      heartbeat <= next_heartbeat;
      sup_count <= next_sup_count;
      sup_active <= next_sup_active;
      pend <= next_pend;
      err <= next_err;
      echo <= next_echo;
      seen_count <= next_seen_count;
      state <= next_state;
      outs <= next_outs;
      run_lamp <= next_run_lamp;
      ready_lamp <= next_ready_lamp;
      accept <= next_accept;
    end
  end
  // Outputs straight from flip-flops
  assign input_status_byte_out = {err, heartbeat, sw_two, sw_one};
  assign echoed_outbound_counter_out = echo;
  assign transfer_accept_out = accept;
  assign resync_request_out = err[`BIT_MASTER_FAULT - 3];
  assign switch_output_one_out = outs[0];
  assign switch_output_two_out = outs[1];
  assign run_lamp_out = run_lamp;
  assign ready_lamp_out = ready_lamp;
  // Checks
  property p_err_clear;
    @(posedge clk_in) disable iff (reset_in)
    (state != XFER_BUSY && master_outbound_counter_in != seen_count) |=> err == 5'h00;
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("errors not cleared");
  property p_ack_echo;
    @(posedge clk_in) disable iff (reset_in)
    (state == XFER_BUSY && transfer_done_in) |=> echo == $past(seen_count);
  endproperty
  a_ack_echo: assert property (p_ack_echo) else $error("echo not updated");
  property p_full_latch;
    @(posedge clk_in) disable iff (reset_in)
    (state == XFER_BUSY && outbound_buffers_full_in) |=> input_status_byte_out[6];
  endproperty
  a_full_latch: assert property (p_full_latch) else $error("full flag lost");
  property p_refuse;
    @(posedge clk_in) disable iff (reset_in)
    input_status_byte_out[3] |-> !transfer_accept_out && resync_request_out;
  endproperty
  a_refuse: assert property (p_refuse) else $error("fault not refusing");
  property p_outs;
    @(posedge clk_in) disable iff (reset_in)
    output_control_write_in |=> switch_output_one_out == $past(output_control_byte_in[0])
      && switch_output_two_out == $past(output_control_byte_in[1]);
  endproperty
  a_outs: assert property (p_outs) else $error("outputs wrong");
  property p_hb_stable;
    @(posedge clk_in) disable iff (reset_in)
    !tick |-> $stable(heartbeat);
  endproperty
  a_hb_stable: assert property (p_hb_stable) else $error("heartbeat moved off tick");
  property p_run_on;
    @(posedge clk_in) disable iff (reset_in)
    run_mode_in == 2'h1 |=> run_lamp_out;
  endproperty
  a_run_on: assert property (p_run_on) else $error("run lamp not on");
  property p_ready_off;
    @(posedge clk_in) disable iff (reset_in)
    ready_mode_in == 2'h0 |=> !ready_lamp_out;
  endproperty
  a_ready_off: assert property (p_ready_off) else $error("ready lamp not off");
  c_ack: cover property (@(posedge clk_in) state == XFER_BUSY ##1 state == XFER_ACKED);
  c_timeout: cover property (@(posedge clk_in) timeout_evt);
  c_hb: cover property (@(posedge clk_in) $rose(heartbeat));
endmodule : gateway_status_io_byte

// File: bench/field_master_model.sv
// Field bus master model driving the outbound counter and output byte
`timescale 1ns/1ps
module field_master_model (
  input wire logic clk_in,
  input wire logic [7:0] echoed_counter_in,
  output logic [7:0] counter_out,
  output logic [7:0] byte_out,
  output logic write_out
);
  // Idle header at time zero
  initial
  begin
    counter_out = 8'h00;
    byte_out = 8'h00;
    write_out = 1'b0;
  end
  // Start the next transfer by stepping the counter
  task automatic start_xfer;
    @(negedge clk_in);
    counter_out = counter_out + 8'h01;
  endtask : start_xfer
  // Wait for the echo before the status is evaluated
  task automatic wait_ack(output bit ok);
    ok = 1'b0;
    for (int n = 0; n < 200 && !ok; n++)
    begin
      @(negedge clk_in);
      ok = (echoed_counter_in === counter_out);
    end
  endtask : wait_ack
  // One write strobe carrying the given byte
  task automatic write_byte(input logic [7:0] b);
    @(negedge clk_in);
    byte_out = b;
    write_out = 1'b1;
    @(negedge clk_in);
    write_out = 1'b0;
  endtask : write_byte
endmodule : field_master_model

// File: bench/gateway_status_io_byte_bench.sv
// Self-checking bench for the status and switching I/O byte block
`timescale 1ns/1ps
module gateway_status_io_byte_bench;
  logic clk_in, reset_in, sw1, sw2, done, sent, resp, wr, accept, resync;
  logic switch_output_one, switch_output_two, run_lamp, ready_lamp;
  logic [3:0] ev;
  logic [1:0] run_mode, ready_mode;
  logic [7:0] status, echo, cnt, obyte;
  logic [7:0] exp_tab [6] = '{8'h80, 8'h40, 8'h20, 8'h08, 8'h10, 8'h00};
  int err_total = 0;
  int checked = 0;
  int cycles = 0;
  // Heartbeat count wide enough that the lamp flash bits move
  gateway_status_io_byte #(.TICK_CYCLES(10), .HEARTBEAT_TICKS(512), .DEBOUNCE_TICKS(2),
    .SUPERVISION_TICKS(3)) u_dut (.clk_in(clk_in), .reset_in(reset_in),
    .switch_input_one_in(sw1), .switch_input_two_in(sw2), .output_control_byte_in(obyte),
    .output_control_write_in(wr), .master_outbound_counter_in(cnt),
    .serial_line_fault_in(ev[0]), .outbound_buffers_full_in(ev[1]),
    .reader_rejected_telegram_in(ev[2]), .reader_telegram_sent_in(sent),
    .reader_response_in(resp), .master_handling_fault_in(ev[3]), .transfer_done_in(done),
    .run_mode_in(run_mode), .ready_mode_in(ready_mode), .input_status_byte_out(status),
    .echoed_outbound_counter_out(echo), .transfer_accept_out(accept),
    .resync_request_out(resync), .switch_output_one_out(switch_output_one),
    .switch_output_two_out(switch_output_two), .run_lamp_out(run_lamp), .ready_lamp_out(ready_lamp));
  field_master_model u_master (.clk_in(clk_in), .echoed_counter_in(echo),
    .counter_out(cnt), .byte_out(obyte), .write_out(wr));
  // Clock at 125 MHz
  initial
  begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  // Hang guard
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      err_total++;
      give_verdict;
    end
  end
  task automatic give_verdict;
    if (err_total == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask : cyc
  // Reset state of every output
  task automatic chk_reset;
    chk({2'h0, switch_output_two, switch_output_one, run_lamp, ready_lamp, resync, accept}, 8'h01);
    chk(status, 8'h00);
    chk(echo, 8'h00);
  endtask : chk_reset
  // One transfer with a chosen event; k 4 is a reader timeout, k 5 a timely answer
  task automatic xfer(input int k);
    bit ok;
    u_master.start_xfer;
    cyc(3);
    chk(status & 8'hf8, 8'h00);
    chk({7'h0, accept}, 8'h01);
    if (k < 4)
    begin
      ev[k] = 1'b1;
      cyc(1);
      ev = 4'h0;
    end
    else
    begin
      sent = (k > 3);
      cyc(1);
      sent = 1'b0;
      resp = (k == 5);
      cyc(1);
      resp = 1'b0;
      cyc(50);
    end
    // Full and master-fault events acknowledge by themselves
    done = (k != 1) && (k != 3);
    cyc(1);
    done = 1'b0;
    u_master.wait_ack(ok);
    chk({7'h0, ok}, 8'h01);
    chk(status & 8'hf8, exp_tab[k]);
    chk({6'h0, resync, accept}, {6'h0, exp_tab[k][3], ~(exp_tab[k][6] | exp_tab[k][3])});
  endtask : xfer
  // Main sequence
  initial
  begin
    logic [3:0] seen;
    logic h;
    int n;
    reset_in = 1'b1;
    {sw1, sw2, done, sent, resp} = 5'h00;
    ev = 4'h0;
    run_mode = 2'h0;
    ready_mode = 2'h0;
    repeat (12) @(posedge clk_in);
    @(negedge clk_in);
    chk_reset;
    reset_in = 1'b0;
    for (int k = 0; k < 6; k++)
      xfer(k);
    sw1 = 1'b1;
    cyc(5);
    chk(status & 8'h03, 8'h00);
    cyc(60);
    chk(status & 8'h03, 8'h01);
    sw1 = 1'b0;
    sw2 = 1'b1;
    cyc(60);
    chk(status & 8'h03, 8'h02);
    n = 0;
    repeat (2)
    begin
      h = status[2];
      n = 0;
      while (status[2] === h && n < 6000)
      begin
        cyc(1);
        n++;
      end
    end
    // Half period is 512 ticks of 10 cycles
    chk(n[15:8], 8'h14);
    chk(n[7:0], 8'h00);
    for (int m = 0; m < 4; m++)
    begin
      run_mode = m[1:0];
      ready_mode = m[1:0];
      cyc(3);
      seen = 4'h0;
      repeat (6000)
      begin
        cyc(1);
        seen = seen | {run_lamp === 1'b1, run_lamp === 1'b0, ready_lamp === 1'b1,
          ready_lamp === 1'b0};
      end
      chk({4'h0, seen}, (m == 0) ? 8'h05 : (m == 1) ? 8'h0a : 8'h0f);
    end
    run_mode = 2'h0;
    ready_mode = 2'h0;
    u_master.write_byte(8'hfd);
    cyc(2);
    chk({6'h0, switch_output_two, switch_output_one}, 8'h01);
    u_master.write_byte(8'h02);
    cyc(2);
    chk({6'h0, switch_output_two, switch_output_one}, 8'h02);
    sw2 = 1'b0;
    reset_in = 1'b1;
    cyc(2);
    chk_reset;
    reset_in = 1'b0;
    cyc(2);
    give_verdict;
  end
endmodule : gateway_status_io_byte_bench
